// >>> core/irpc_timer.sv
// ir pulse counter/timer pair: 8-bit short counter, 16-bit long counter, AXI4-Lite registers
// assumes synchronous pin inputs, one clock, software keeps to the documented write order
//
// Summary of operation
// RQ1: filtered selected pin gives one pulse per edge of chosen polarity
// RQ2: input pulses narrower than the chosen glitch width are discarded
// RQ3: disabled short counter in transmit drives inverse of its initial level
// RQ4: enabling short counter drives initial level, loads low or high hold
// RQ5: single pass: count to zero, stop, toggle, set time-out, request interrupt
// RQ6: modulo-N: toggle and reload each terminal, flag once per low/high cycle
// RQ7: hold values only take effect at the next reload
// RQ8: short count of one forbidden; zero wraps to ff without time-out
// RQ9: stop and flag clears act one prescaled tick after the write
// RQ10: short demodulation starts counting at the first qualifying edge
// RQ11: later edges capture inverted count into rise/fall register, flag, reload
// RQ12: short demodulation zero sets time-out and keeps counting from ff
// RQ13: long output inverse of initial level when idle; submodes 10/11 force it
// RQ14: enabling long counter loads upper*256+lower, drives initial level
// RQ15: long zero toggles output, flags, then stops or reloads by mode
// RQ16: long count of one forbidden; zero wraps to ffff without time-out
// RQ17: long demodulation first edge captures, reloads and starts counting
// RQ18: with edge-ignore clear, each edge captures inverted count, flags, reloads
// RQ19: edge-ignore set: short time-out snapshots count; 0 then 1 rearms once
// RQ20: long demodulation zero sets time-out and continues from ffff
// RQ21: ping-pong: each counter stops itself and starts the other at terminal
// RQ22: software stops both, sets single pass and ping-pong, then enables one
// RQ23: glitch width selectable as none, 4, 8 or 16 clocks
// RQ24: each counter ticks at clock divided by 1, 2, 4 or 8
// RQ25: combined output is AND, OR, NOR or NAND of both outputs
// RQ26: time-out and edge flags clear only by writing one
// RQ27: enabled counters decrement once per tick and hold while disabled
module irpc_timer
  import irpc_pkg::*;
(
  // clocking
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  // register bus
  input wire irpc_axi_req_type axiReq,
  output irpc_axi_rsp_type axiRsp,
  // pins
  input wire logic demodPinA,
  input wire logic demodPinB,
  output irpc_pins_type pins
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl0_q, ctrl1_q, ctrl2_q;
  logic [7:0] sLow_q, sHigh_q, lLow_q, lHigh_q, sRise_q, sFall_q;
  logic [15:0] lCap_q, lCnt_q;
  logic [7:0] sCnt_q;
  logic sOut_q, lOut_q, prevLvl_q;
  irpc_state_type sState_q, lState_q;
  logic [2:0] div_q;
  logic sStart_q, sStop_q, sClr_q, lStart_q, lStop_q, lClr_q;
  logic [1:0] eClr_q;
  irpc_axi_rsp_type rsp_q;
  irpc_pins_type pins_q;
  logic [REG_CNT-1:0] wrHit;
  logic [7:0] wrData, rdByte;
  logic rdOk, wrOk;
  logic fLvl, riseE, fallE, edgeAny, demod;
  logic sTick, lTick, sRun, lRun, sTo, lTo, sCap, lCap, lArm, lSnap;
  logic [1:0] sub;

  function automatic logic tickOf(input logic [1:0] sel, input logic [2:0] d);
    case (sel)
      DIV1: tickOf = 1'b1;
      DIV2: tickOf = d[0];
      DIV4: tickOf = &d[1:0];
      default: tickOf = &d;
    endcase
  endfunction : tickOf

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: address and data are taken together, answer one cycle later

  assign wrData = axiReq.wdata[7:0];
  assign wrOk = axiReq.awaddr[AW-1:2] < 4'(REG_CNT) && axiReq.awaddr[AW-1:2] != IDX_HOLE;

  always_comb begin
    if (!rsp_q.awready || !axiReq.wstrb[0] || !wrOk) begin
      wrHit = '0;
    end else begin
      wrHit = REG_CNT'(1) << axiReq.awaddr[AW-1:2];
    end
  end

  always_comb begin
    rdOk = 1'b1;
    if (axiReq.araddr[AW-1:2] == IDX_SCTRL) rdByte = ctrl0_q;
    else if (axiReq.araddr[AW-1:2] == IDX_SHCTRL) rdByte = ctrl1_q;
    else if (axiReq.araddr[AW-1:2] == IDX_LCTRL) rdByte = ctrl2_q;
    else if (axiReq.araddr[AW-1:2] == IDX_SLOW) rdByte = sLow_q;
    else if (axiReq.araddr[AW-1:2] == IDX_SHIGH) rdByte = sHigh_q;
    else if (axiReq.araddr[AW-1:2] == IDX_LLOW) rdByte = lLow_q;
    else if (axiReq.araddr[AW-1:2] == IDX_LHIGH) rdByte = lHigh_q;
    else if (axiReq.araddr[AW-1:2] == IDX_SRISE) rdByte = sRise_q;
    else if (axiReq.araddr[AW-1:2] == IDX_SFALL) rdByte = sFall_q;
    else if (axiReq.araddr[AW-1:2] == IDX_LCAPLO) rdByte = lCap_q[7:0];
    else if (axiReq.araddr[AW-1:2] == IDX_LCAPHI) rdByte = lCap_q[15:8];
    else begin
      rdByte = RST_BYTE;
      rdOk = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp_q <= '0;
    end else if (clkEn) begin
      rsp_q.awready <= axiReq.awvalid & axiReq.wvalid & ~rsp_q.awready & ~rsp_q.bvalid;
      rsp_q.wready <= axiReq.awvalid & axiReq.wvalid & ~rsp_q.awready & ~rsp_q.bvalid;
      if (rsp_q.awready) begin
        rsp_q.bvalid <= 1'b1;
        rsp_q.bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
      end else if (axiReq.bready) begin
        rsp_q.bvalid <= 1'b0;
      end
      rsp_q.arready <= axiReq.arvalid & ~rsp_q.arready & ~rsp_q.rvalid;
      if (rsp_q.arready) begin
        rsp_q.rvalid <= 1'b1;
        rsp_q.rdata <= {24'h000000, rdByte};
        rsp_q.rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (axiReq.rready) begin
        rsp_q.rvalid <= 1'b0;
      end
    end
  end

  assign axiRsp = rsp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // input path, prescaler and event terms

  assign demod = ctrl1_q[BIT_MODE];
  assign sub = ctrl1_q[SUB_HI:SUB_LO];

  irpc_glitch_filter irpc_glitch_filter_inst (
    .clock(clock),
    .rstn(rstn),
    .clkEn(clkEn),
    .din(ctrl1_q[BIT_SEL] ? demodPinB : demodPinA),
    .widthSel(demod ? sub : FILT_NONE),
    .dout(fLvl)
  );

  // polarity code 11 is reserved and detects nothing [RQ1]
  assign riseE = fLvl & ~prevLvl_q & (ctrl1_q[LOG_HI:LOG_LO] inside {EDGE_RISE, EDGE_BOTH});
  assign fallE = ~fLvl & prevLvl_q & (ctrl1_q[LOG_HI:LOG_LO] inside {EDGE_FALL, EDGE_BOTH});
  assign edgeAny = demod & (riseE | fallE);

  assign sTick = tickOf(ctrl0_q[CLK_HI:CLK_LO], div_q); // [RQ24]
  assign lTick = tickOf(ctrl2_q[CLK_HI:CLK_LO], div_q); // [RQ24]
  assign sRun = sTick & sState_q == ST_RUN & ~sStop_q & ~sStart_q;
  assign lRun = lTick & lState_q == ST_RUN & ~lStop_q & ~lStart_q;
  assign sCap = edgeAny & sState_q == ST_RUN;
  assign lCap = edgeAny & lState_q == ST_RUN & ~ctrl2_q[BIT_SINGLE];
  assign lArm = edgeAny & lState_q == ST_ARM;
  // only the count reaching zero from one is a time-out, never the wrap [RQ8] [RQ16]
  assign sTo = sRun & ~sCap & sCnt_q == ONE8
    & (demod | ctrl0_q[BIT_SINGLE] | (sOut_q ^ ctrl1_q[BIT_RISE])); // [RQ5] [RQ6] [RQ12]
  assign lTo = lRun & ~lCap & ~lArm & lCnt_q == ONE16; // [RQ15] [RQ20]
  assign lSnap = demod & sTo & lState_q == ST_RUN & ctrl2_q[BIT_SINGLE]; // [RQ19]

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_q <= 3'h0;
      prevLvl_q <= 1'b0;
    end else if (clkEn) begin
      div_q <= div_q + 3'h1;
      prevLvl_q <= fLvl;
    end
  end

  // hold registers are only copied into a counter on a load [RQ7]
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {sLow_q, sHigh_q, lLow_q, lHigh_q} <= {4{RST_BYTE}};
    end else if (clkEn) begin
      if (wrHit[IDX_SLOW]) sLow_q <= wrData;
      if (wrHit[IDX_SHIGH]) sHigh_q <= wrData;
      if (wrHit[IDX_LLOW]) lLow_q <= wrData;
      if (wrHit[IDX_LHIGH]) lHigh_q <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared control; in demodulation its low bits are the edge flags

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl1_q <= RST_BYTE;
      eClr_q <= 2'h0;
    end else if (clkEn) begin
      if (sTick) begin
        ctrl1_q[BIT_RISE:BIT_FALL] <= ctrl1_q[BIT_RISE:BIT_FALL] & ~eClr_q; // [RQ9]
        eClr_q <= 2'h0;
      end
      if (wrHit[IDX_SHCTRL]) begin
        ctrl1_q[BIT_MODE:SUB_LO] <= wrData[BIT_MODE:SUB_LO];
        if (!wrData[BIT_MODE]) ctrl1_q[BIT_RISE:BIT_FALL] <= wrData[BIT_RISE:BIT_FALL];
        else eClr_q <= wrData[BIT_RISE:BIT_FALL]; // [RQ26]
      end
      // a captured edge beats a pending clear
      if (sCap | lCap) begin
        if (riseE) ctrl1_q[BIT_RISE] <= 1'b1; // [RQ11] [RQ18]
        if (fallE) ctrl1_q[BIT_FALL] <= 1'b1; // [RQ11] [RQ18]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // short counter

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl0_q <= RST_BYTE;
      sCnt_q <= RST_BYTE;
      sOut_q <= 1'b0;
      sState_q <= ST_IDLE;
      {sStart_q, sStop_q, sClr_q} <= 3'h0;
      {sRise_q, sFall_q} <= {2{RST_BYTE}};
    end else if (clkEn) begin
      if (!demod && sState_q == ST_IDLE) sOut_q <= ~ctrl1_q[BIT_RISE]; // [RQ3]
      if (sTick) begin
        {sStart_q, sStop_q, sClr_q} <= 3'h0;
        if (sClr_q) ctrl0_q[BIT_TO] <= 1'b0; // [RQ9] [RQ26]
        if (sStop_q) begin
          ctrl0_q[BIT_EN] <= 1'b0; // [RQ9]
          sState_q <= ST_IDLE;
        end else if (sStart_q) begin
          ctrl0_q[BIT_EN] <= 1'b1;
          sState_q <= demod ? ST_ARM : ST_RUN; // [RQ10]
          sOut_q <= ctrl1_q[BIT_RISE]; // [RQ4]
          sCnt_q <= ctrl1_q[BIT_RISE] ? sHigh_q : sLow_q; // [RQ4]
        end else if (sState_q == ST_RUN) begin
          sCnt_q <= sCnt_q - ONE8; // [RQ27] [RQ12]
          if (sCnt_q == ONE8 && !demod) begin
            sOut_q <= ~sOut_q; // [RQ5] [RQ6]
            if (ctrl0_q[BIT_SINGLE]) begin
              ctrl0_q[BIT_EN] <= 1'b0; // [RQ5] [RQ21]
              sState_q <= ST_IDLE;
            end else begin
              sCnt_q <= sOut_q ? sLow_q : sHigh_q; // [RQ6]
            end
          end
        end
      end
      if (wrHit[IDX_SCTRL]) begin
        ctrl0_q[BIT_SINGLE] <= wrData[BIT_SINGLE];
        ctrl0_q[CLK_HI:BIT_PIN] <= wrData[CLK_HI:BIT_PIN];
        sStart_q <= wrData[BIT_EN] & sState_q == ST_IDLE;
        sStop_q <= ~wrData[BIT_EN];
        sClr_q <= wrData[BIT_TO];
      end
      if (lTo && !demod && sub == SUB_PING) sStart_q <= 1'b1; // [RQ21]
      if (edgeAny && sState_q == ST_ARM) begin
        sState_q <= ST_RUN; // [RQ10]
        sCnt_q <= ONES8;
      end
      if (sCap) begin
        sCnt_q <= ONES8; // [RQ11]
        if (riseE) sRise_q <= ~sCnt_q; // [RQ11]
        else sFall_q <= ~sCnt_q; // [RQ11]
      end
      if (sTo) ctrl0_q[BIT_TO] <= 1'b1; // [RQ5] [RQ12] [RQ26]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // long counter

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl2_q <= RST_BYTE;
      lCnt_q <= ONES16;
      lOut_q <= 1'b0;
      lState_q <= ST_IDLE;
      {lStart_q, lStop_q, lClr_q} <= 3'h0;
      lCap_q <= ONES16;
    end else if (clkEn) begin
      if (!demod && lState_q == ST_IDLE) lOut_q <= ~ctrl1_q[BIT_FALL]; // [RQ13]
      if (lTick) begin
        {lStart_q, lStop_q, lClr_q} <= 3'h0;
        if (lClr_q) ctrl2_q[BIT_TO] <= 1'b0; // [RQ9] [RQ26]
        if (lStop_q) begin
          ctrl2_q[BIT_EN] <= 1'b0; // [RQ9]
          lState_q <= ST_IDLE;
        end else if (lStart_q) begin
          ctrl2_q[BIT_EN] <= 1'b1;
          lState_q <= demod ? ST_ARM : ST_RUN; // [RQ17]
          lOut_q <= ctrl1_q[BIT_FALL]; // [RQ14]
          lCnt_q <= {lHigh_q, lLow_q}; // [RQ14]
        end else if (lState_q == ST_RUN) begin
          lCnt_q <= lCnt_q - ONE16; // [RQ27] [RQ20]
          if (lCnt_q == ONE16 && !demod) begin
            if (!sub[1]) lOut_q <= ~lOut_q; // [RQ15]
            if (ctrl2_q[BIT_SINGLE]) begin
              ctrl2_q[BIT_EN] <= 1'b0; // [RQ15] [RQ21]
              lState_q <= ST_IDLE;
            end else begin
              lCnt_q <= {lHigh_q, lLow_q}; // [RQ15]
            end
          end
        end
      end
      if (wrHit[IDX_LCTRL]) begin
        ctrl2_q[BIT_SINGLE] <= wrData[BIT_SINGLE];
        ctrl2_q[CLK_HI:BIT_PIN] <= wrData[CLK_HI:BIT_PIN];
        lStart_q <= wrData[BIT_EN] & lState_q == ST_IDLE;
        lStop_q <= ~wrData[BIT_EN];
        lClr_q <= wrData[BIT_TO];
        // clearing then setting the ignore bit rearms one capture [RQ19]
        if (demod && lState_q == ST_RUN && wrData[BIT_SINGLE] && !ctrl2_q[BIT_SINGLE])
          lState_q <= ST_ARM;
      end
      if (sTo && !demod && sub == SUB_PING) lStart_q <= 1'b1; // [RQ21]
      if (lArm || lCap) begin
        lState_q <= ST_RUN; // [RQ17] [RQ18]
        lCnt_q <= ONES16;
        lCap_q <= ~lCnt_q; // [RQ17] [RQ18]
      end
      if (lSnap) lCap_q <= ~lCnt_q; // [RQ19]
      if (lTo) ctrl2_q[BIT_TO] <= 1'b1; // [RQ15] [RQ20] [RQ26]
      if (!demod && sub[1]) lOut_q <= sub[0]; // [RQ13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins: every output is registered, so they trail internal state by one cycle

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pins_q <= '0;
    end else if (clkEn) begin
      pins_q.shortOut <= sOut_q;
      pins_q.shortSel <= ctrl0_q[BIT_PIN];
      pins_q.longOut <= lOut_q;
      pins_q.longSel <= ctrl2_q[BIT_PIN];
      pins_q.combSel <= ctrl1_q[BIT_SEL] & ~demod;
      case (ctrl1_q[LOG_HI:LOG_LO])
        LOG_AND: pins_q.combOut <= ~demod & (sOut_q & lOut_q); // [RQ25]
        LOG_OR: pins_q.combOut <= ~demod & (sOut_q | lOut_q); // [RQ25]
        LOG_NOR: pins_q.combOut <= ~demod & ~(sOut_q | lOut_q); // [RQ25]
        default: pins_q.combOut <= ~demod & ~(sOut_q & lOut_q); // [RQ25]
      endcase
      pins_q.irqShort <= (sTo & ctrl0_q[BIT_TOMSK]) | (sCap & ctrl0_q[BIT_CAPMSK]); // [RQ5]
      pins_q.irqLong <= (lTo & ctrl2_q[BIT_TOMSK])
        | ((lCap | lSnap) & ctrl2_q[BIT_CAPMSK]); // [RQ15] [RQ18] [RQ19]
    end
  end

  assign pins = pins_q;

  ////////////////////////////////////////////////////////////////////////////////

  edge_single_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ1]
    (clkEn && riseE) |-> !fallE ##1 (!riseE || !clkEn))
    else $error("edge pulse lasted more than one cycle");

  idle_short_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ3]
    (clkEn && !demod && sState_q == ST_IDLE && !sStart_q) |=> sOut_q == !$past(ctrl1_q[BIT_RISE]))
    else $error("idle short output not inverse of initial level");

  wrap_quiet_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ8]
    (clkEn && sRun && sCnt_q == RST_BYTE && !sCap)
    |=> sCnt_q == ONES8 && !$rose(ctrl0_q[BIT_TO]))
    else $error("wrap from zero raised a time-out");

  timeout_set_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ5]
    (clkEn && sTo) |=> ctrl0_q[BIT_TO] ##1 (ctrl0_q[BIT_TO] || $past(sClr_q)))
    else $error("time-out flag not set");

  capture_value_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ11]
    (clkEn && sCap && riseE) |=> sRise_q == ~$past(sCnt_q) && sCnt_q == ONES8)
    else $error("short capture or reload wrong");

  modulo_reload_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ6]
    (clkEn && sRun && !demod && !ctrl0_q[BIT_SINGLE] && sCnt_q == ONE8 && !sOut_q)
    |=> sCnt_q == $past(sHigh_q) && sOut_q)
    else $error("modulo reload took wrong hold value");

  force_long_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ13]
    (clkEn && !demod && sub[1]) |=> lOut_q == $past(sub[0]))
    else $error("forced long output wrong");

  long_capture_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ18]
    (clkEn && lCap) |=> lCap_q == ~$past(lCnt_q) && lCnt_q == ONES16)
    else $error("long capture or reload wrong");

  ping_handoff_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ21]
    (clkEn && sTo && !demod && sub == SUB_PING && ctrl0_q[BIT_SINGLE]) |=> lStart_q)
    else $error("ping-pong did not hand over");

endmodule : irpc_timer

// >>> inc/irpc_pkg.sv
// package for the ir pulse counter/timer pair: register map, fields, codes, bus carriers
// assumes a 40 MHz system clock and an AXI4-Lite master with 32-bit data
package irpc_pkg;

  localparam int REG_CNT = 12;
  localparam int AW = 6;
  localparam int CLK_HZ = 40000000;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_SCTRL = 4'h0;
  localparam logic [3:0] IDX_SHCTRL = 4'h1;
  localparam logic [3:0] IDX_LCTRL = 4'h2;
  localparam logic [3:0] IDX_HOLE = 4'h3;
  localparam logic [3:0] IDX_SLOW = 4'h4;
  localparam logic [3:0] IDX_SHIGH = 4'h5;
  localparam logic [3:0] IDX_LLOW = 4'h6;
  localparam logic [3:0] IDX_LHIGH = 4'h7;
  localparam logic [3:0] IDX_SRISE = 4'h8;
  localparam logic [3:0] IDX_SFALL = 4'h9;
  localparam logic [3:0] IDX_LCAPLO = 4'ha;
  localparam logic [3:0] IDX_LCAPHI = 4'hb;

  // counter control bits
  localparam int BIT_EN = 7;
  localparam int BIT_SINGLE = 6;
  localparam int BIT_TO = 5;
  localparam int CLK_HI = 4;
  localparam int CLK_LO = 3;
  localparam int BIT_CAPMSK = 2;
  localparam int BIT_TOMSK = 1;
  localparam int BIT_PIN = 0;
  // shared control bits
  localparam int BIT_MODE = 7;
  localparam int BIT_SEL = 6;
  localparam int LOG_HI = 5;
  localparam int LOG_LO = 4;
  localparam int SUB_HI = 3;
  localparam int SUB_LO = 2;
  localparam int BIT_RISE = 1;
  localparam int BIT_FALL = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ONES8 = 8'hff;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [15:0] ONES16 = 16'hffff;
  localparam logic [15:0] ONE16 = 16'h0001;

  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PING = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] LOG_AND = 2'h0;
  localparam logic [1:0] LOG_OR = 2'h1;
  localparam logic [1:0] LOG_NOR = 2'h2;
  localparam logic [1:0] DIV1 = 2'h0;
  localparam logic [1:0] DIV2 = 2'h1;
  localparam logic [1:0] DIV4 = 2'h2;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_4 = 2'h1;
  localparam logic [1:0] FILT_8 = 2'h2;
  localparam logic [4:0] F_W0 = 5'h00;
  localparam logic [4:0] F_W4 = 5'h04;
  localparam logic [4:0] F_W8 = 5'h08;
  localparam logic [4:0] F_W16 = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_RUN = 2'b10
  } irpc_state_type;

  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } irpc_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } irpc_axi_rsp_type;

  typedef struct packed {
    logic shortOut;
    logic shortSel;
    logic longOut;
    logic longSel;
    logic combOut;
    logic combSel;
    logic irqShort;
    logic irqLong;
  } irpc_pins_type;

endpackage : irpc_pkg

// >>> core/irpc_glitch_filter.sv
// glitch filter: the output follows the input only after it has held steady long enough
// assumes the input is synchronous to clock
module irpc_glitch_filter
  import irpc_pkg::*;
(
  // clocking
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  // level in and out
  input wire logic din,
  input wire logic [1:0] widthSel,
  output logic dout
);

  logic [4:0] limit;
  logic [4:0] cnt_q;
  logic dout_q;

  always_comb begin
    case (widthSel)
      FILT_NONE: limit = F_W0;
      FILT_4: limit = F_W4;
      FILT_8: limit = F_W8;
      default: limit = F_W16;
    endcase
  end

  // a pulse shorter than limit cycles never reaches the output [RQ2] [RQ23]
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 5'h00;
      dout_q <= 1'b0;
    end else if (clkEn) begin
      if (din == dout_q) begin
        cnt_q <= 5'h00;
      end else if (cnt_q + 5'h01 >= limit) begin
        cnt_q <= 5'h00;
        dout_q <= din;
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  assign dout = dout_q;

  glitch_hold_a: assert property (@(posedge clock) disable iff (!rstn) // [RQ2]
    (clkEn && din != dout_q && cnt_q + 5'h01 < limit) |=> $stable(dout_q))
    else $error("filter passed a short pulse");

endmodule : irpc_glitch_filter

// >>> testbench/irpc_timer_tb.sv
// bench for irpc_timer: axi4-lite register traffic and pin checks, one task per scenario
// assumes the register map of irpc_pkg and a 40 MHz clock; clkEn and pin b stay fixed
module irpc_timer_tb
  import irpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic clkEn = 1'b1;
  logic demodPinA = 1'b0;
  logic demodPinB = 1'b0;
  irpc_axi_req_type axiReq = '0;
  irpc_axi_rsp_type axiRsp;
  irpc_pins_type pins;
  int miscompares = 0;
  int cmp_count = 0;
  int irqS = 0;
  int irqL = 0;
  int n;
  logic [31:0] rd;
  logic [1:0] rs;
  always #12.5 clock = ~clock;
  // interrupt pins pulse for one cycle, so count them where they stand
  always @(posedge clock) begin
    if (pins.irqShort === 1'b1) irqS <= irqS + 1;
    if (pins.irqLong === 1'b1) irqL <= irqL + 1;
  end
  irpc_timer irpc_timer_inst (.clock(clock), .rstn(rstn), .clkEn(clkEn), .axiReq(axiReq),
    .axiRsp(axiRsp), .demodPinA(demodPinA), .demodPinB(demodPinB), .pins(pins));
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one task for both directions; waits as long as the slave takes, the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    @(posedge clock);
    axiReq.awaddr <= {idx, 2'b00};
    axiReq.araddr <= {idx, 2'b00};
    axiReq.wdata <= {24'h000000, d};
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= w;
    axiReq.wvalid <= w;
    axiReq.bready <= w;
    axiReq.arvalid <= !w;
    axiReq.rready <= !w;
    do begin
      @(posedge clock);
    end while ((w ? axiRsp.awready : axiRsp.arready) !== 1'b1);
    axiReq.awvalid <= 1'b0;
    axiReq.wvalid <= 1'b0;
    axiReq.arvalid <= 1'b0;
    do begin
      @(posedge clock);
    end while ((w ? axiRsp.bvalid : axiRsp.rvalid) !== 1'b1);
    rs = w ? axiRsp.bresp : axiRsp.rresp;
    rd = axiRsp.rdata;
    axiReq.bready <= 1'b0;
    axiReq.rready <= 1'b0;
  endtask : bus
  // n ends as the number of edges until the chosen output shows v
  task automatic wp(input logic lng, input logic v);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((lng ? pins.longOut : pins.shortOut) !== v && n < 600);
  endtask : wp
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    bus(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h00000000);
    bus(1'b0, 4'h8, 8'h00);
    chk(rd, 32'h00000000);
    bus(1'b0, 4'h3, 8'h00);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    chk(rd, 32'h00000000);
    chk({31'h0, pins.shortOut}, 32'h1);
    chk({31'h0, pins.longOut}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_single();
    bus(1'b1, 4'h4, 8'h03);
    bus(1'b1, 4'h0, 8'hc0);
    wp(1'b0, 1'b0);
    wp(1'b0, 1'b1);
    chk(n, 3);
    bus(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h00000060);
    bus(1'b1, 4'h0, 8'h40);
    bus(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h00000060);
    bus(1'b1, 4'h0, 8'h60);
    bus(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h00000040);
    $display("test single pass done");
  endtask : t_single
  task automatic t_high();
    bus(1'b1, 4'h1, 8'h02);
    repeat (3) @(posedge clock);
    chk({31'h0, pins.shortOut}, 32'h0);
    bus(1'b1, 4'h5, 8'h05);
    bus(1'b1, 4'h0, 8'h80);
    wp(1'b0, 1'b1);
    wp(1'b0, 1'b0);
    chk(n, 5);
    wp(1'b0, 1'b1);
    chk(n, 3);
    bus(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h000000a0);
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'h0, 8'h20);
    bus(1'b1, 4'h1, 8'h00);
    $display("test high hold done");
  endtask : t_high
  task automatic t_long();
    bus(1'b1, 4'h6, 8'h02);
    bus(1'b1, 4'h7, 8'h01);
    bus(1'b1, 4'h2, 8'hc3);
    wp(1'b1, 1'b0);
    wp(1'b1, 1'b1);
    chk(n, 258);
    chk(irqL, 1);
    chk({31'h0, pins.longSel}, 32'h1);
    bus(1'b0, 4'h2, 8'h00);
    chk(rd, 32'h00000063);
    bus(1'b1, 4'h1, 8'h08);
    repeat (3) @(posedge clock);
    chk({31'h0, pins.longOut}, 32'h0);
    bus(1'b1, 4'h1, 8'h0c);
    repeat (3) @(posedge clock);
    chk({31'h0, pins.longOut}, 32'h1);
    $display("test long counter done");
  endtask : t_long
  // both outputs idle high here, so and/or give 1 and nor/nand give 0
  task automatic t_comb();
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 4'h1, {2'b01, c[1:0], 4'h0});
      repeat (3) @(posedge clock);
      chk({31'h0, pins.combOut}, {31'h0, c < 2});
    end
    chk({31'h0, pins.combSel}, 32'h1);
    $display("test combined output done");
  endtask : t_comb
  task automatic t_demod();
    bus(1'b1, 4'h1, 8'h90);
    bus(1'b1, 4'h4, 8'hff);
    bus(1'b1, 4'h5, 8'hff);
    bus(1'b1, 4'h6, 8'hff);
    bus(1'b1, 4'h7, 8'hff);
    bus(1'b1, 4'h0, 8'h80);
    bus(1'b1, 4'h2, 8'h80);
    for (int i = 0; i < 3; i++) begin
      demodPinA <= !demodPinA;
      repeat (10) @(posedge clock);
    end
    bus(1'b0, 4'h1, 8'h00);
    chk(rd, 32'h00000092);
    // rises 20 clocks apart: 19 ticks counted down from all ones
    bus(1'b0, 4'h8, 8'h00);
    chk(rd, 32'h00000013);
    bus(1'b0, 4'ha, 8'h00);
    chk(rd, 32'h00000013);
    bus(1'b1, 4'h1, 8'h9e);
    demodPinA <= 1'b0;
    repeat (8) @(posedge clock);
    demodPinA <= 1'b1;
    repeat (20) @(posedge clock);
    bus(1'b0, 4'h1, 8'h00);
    chk(rd, 32'h0000009c);
    $display("test demodulation done");
  endtask : t_demod
  task automatic t_ping();
    bus(1'b1, 4'h0, 8'h40);
    bus(1'b1, 4'h2, 8'h40);
    bus(1'b1, 4'h0, 8'h60);
    bus(1'b1, 4'h2, 8'h60);
    bus(1'b1, 4'h4, 8'h04);
    bus(1'b1, 4'h1, 8'h04);
    bus(1'b1, 4'h0, 8'hc3);
    wp(1'b0, 1'b0);
    wp(1'b0, 1'b1);
    chk(n, 4);
    chk(irqS, 1);
    chk({31'h0, pins.shortSel}, 32'h1);
    bus(1'b0, 4'h2, 8'h00);
    chk(rd, 32'h000000c0);
    bus(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h00000063);
    bus(1'b1, 4'h1, 8'h00);
    bus(1'b1, 4'h2, 8'h40);
    $display("test ping-pong done");
  endtask : t_ping
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // the whole sequence needs well under a thousand cycles; 8000 leaves margin
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_single();
    t_high();
    t_long();
    t_comb();
    t_demod();
    t_ping();
    end_sim();
  end
endmodule : irpc_timer_tb
